// ==== verilog/input_cal_regs.sv ====
// paged calibration registers for input current sense
`timescale 1ns/100ps
// What this block does
// - trim scales current relative to nominal fifty
// - config register paged: 00h chan a, 01h b
// - input calibration shared by both channels
// - page 0 bits 15:8 hold gain trim
// - page 1 bit 13 boosts analog gain
// - page 1 bits 12:8 hold offset trim
// - offset codes are signed tenths of ampere
// - bits 7:0 hold per-channel current ceiling
// - settings feed input and output telemetry
// - gain select bits 15:14 hold resistance code
// - boost and code select one of eight gains
module input_cal_regs
  import cal_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [7:0]         req_cmd,
  input  wire logic [7:0]         req_page,
  input  wire logic [15:0]        req_wdata,
  output logic                    rsp_valid,
  output logic                    rsp_nak,
  output logic [15:0]             rsp_data,
  input  wire logic               nvm_load,
  input  wire logic [15:0]        nvm_config_a,
  input  wire logic [15:0]        nvm_config_b,
  input  wire logic [15:0]        nvm_gain_select,
  input  wire logic [15:0]        sense_uv,
  input  wire logic [11:0]        iout_a_raw,
  input  wire logic [11:0]        iout_b_raw,
  output logic signed [25:0]      iin_report,
  output logic [11:0]             iout_a_report,
  output logic [11:0]             iout_b_report,
  output logic                    iout_a_over,
  output logic                    iout_b_over
);
  logic [7:0]  trim;
  logic        boost;
  logic [4:0]  offset;
  logic [7:0]  ceiling_a;
  logic [7:0]  ceiling_b;
  logic [1:0]  rgain;
  logic [12:0] factory_reserved_bits;
  logic [7:0]  next_trim;
  logic        next_boost;
  logic [4:0]  next_offset;
  logic [7:0]  next_ceiling_a;
  logic [7:0]  next_ceiling_b;
  logic [1:0]  next_rgain;
  logic [12:0] next_factory_reserved_bits;
  logic        next_rsp_valid;
  logic        next_rsp_nak;
  logic [15:0] next_rsp_data;
  logic        hit_cfg;
  logic        hit_gain;
  logic        page_a;
  logic        page_b;
  logic        wr;

  always_comb begin
    hit_cfg  = req_cmd == CMD_INPUT_SENSE_CONFIG;
    hit_gain = req_cmd == CMD_INPUT_GAIN_SELECT;
    page_a   = req_page == PAGE_CHAN_A;
    page_b   = req_page == PAGE_CHAN_B;
    wr       = req_valid && req_write && !nvm_load;

    next_trim                  = trim;
    next_boost                 = boost;
    next_offset                = offset;
    next_ceiling_a             = ceiling_a;
    next_ceiling_b             = ceiling_b;
    next_rgain                 = rgain;
    next_factory_reserved_bits = factory_reserved_bits;

    if (nvm_load) begin
      next_trim                  = nvm_config_a[TRIM_MSB:TRIM_LSB];
      next_ceiling_a             = nvm_config_a[CEILING_MSB:CEILING_LSB];
      next_boost                 = nvm_config_b[BOOST_BIT];
      next_offset                = nvm_config_b[OFFSET_MSB:OFFSET_LSB];
      next_ceiling_b             = nvm_config_b[CEILING_MSB:CEILING_LSB];
      next_rgain                 = nvm_gain_select[RGAIN_MSB:RGAIN_LSB];
      next_factory_reserved_bits = nvm_gain_select[FACTORY_MSB:FACTORY_LSB];
    end else if (wr && hit_cfg && page_a) begin
      next_trim      = req_wdata[TRIM_MSB:TRIM_LSB];
      next_ceiling_a = req_wdata[CEILING_MSB:CEILING_LSB];
    end else if (wr && hit_cfg && page_b) begin
      next_boost     = req_wdata[BOOST_BIT];
      next_offset    = req_wdata[OFFSET_MSB:OFFSET_LSB];
      next_ceiling_b = req_wdata[CEILING_MSB:CEILING_LSB];
    end else if (wr && hit_gain && page_a) begin
      next_rgain                 = req_wdata[RGAIN_MSB:RGAIN_LSB];
      next_factory_reserved_bits = req_wdata[FACTORY_MSB:FACTORY_LSB];
    end

    // one answer per request; unknown command, or page other than 00h and 01h, is refused
    next_rsp_valid = req_valid;
    next_rsp_nak   = req_valid && !((hit_cfg || hit_gain) && (page_a || page_b));
    next_rsp_data  = 16'h0000;
    if (req_valid && !req_write && hit_cfg && page_a) begin
      next_rsp_data = {trim, ceiling_a};
    end else if (req_valid && !req_write && hit_cfg && page_b) begin
      next_rsp_data = {2'b00, boost, offset, ceiling_b};
    end else if (req_valid && !req_write && hit_gain && page_a) begin
      next_rsp_data = {rgain, 1'b0, factory_reserved_bits};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trim                  <= TRIM_RESET;
      boost                 <= 1'b0;
      offset                <= OFFSET_RESET;
      ceiling_a             <= CEILING_RESET;
      ceiling_b             <= CEILING_RESET;
      rgain                 <= RGAIN_RESET;
      factory_reserved_bits <= FACTORY_RESET;
      rsp_valid             <= 1'b0;
      rsp_nak               <= 1'b0;
      rsp_data              <= 16'h0000;
    end else begin
      trim                  <= next_trim;
      boost                 <= next_boost;
      offset                <= next_offset;
      ceiling_a             <= next_ceiling_a;
      ceiling_b             <= next_ceiling_b;
      rgain                 <= next_rgain;
      factory_reserved_bits <= next_factory_reserved_bits;
      rsp_valid             <= next_rsp_valid;
      rsp_nak               <= next_rsp_nak;
      rsp_data              <= next_rsp_data;
    end
  end

  // one shared calibration drives input telemetry; per-channel ceilings clamp output telemetry
  iin_calc u_calc (
    .clk           (clk),
    .rst_b         (rst_b),
    .sense_uv      (sense_uv),
    .iout_a_raw    (iout_a_raw),
    .iout_b_raw    (iout_b_raw),
    .trim          (trim),
    .boost         (boost),
    .rgain         (rgain),
    .offset        (offset),
    .ceiling_a     (ceiling_a),
    .ceiling_b     (ceiling_b),
    .iin_report    (iin_report),
    .iout_a_report (iout_a_report),
    .iout_b_report (iout_b_report),
    .iout_a_over   (iout_a_over),
    .iout_b_over   (iout_b_over)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_cfg_write_a;
    req_valid && req_write && !nvm_load && req_cmd == CMD_INPUT_SENSE_CONFIG
      && req_page == PAGE_CHAN_A;
  endsequence
  sequence s_cfg_write_b;
    req_valid && req_write && !nvm_load && req_cmd == CMD_INPUT_SENSE_CONFIG
      && req_page == PAGE_CHAN_B;
  endsequence
  sequence s_cfg_read_a;
    req_valid && !req_write && !nvm_load && req_cmd == CMD_INPUT_SENSE_CONFIG
      && req_page == PAGE_CHAN_A;
  endsequence

  AST_TRIM_PAGE_A: assert property (
    s_cfg_write_a |=> trim == $past(req_wdata[15:8]) && $stable(offset))
    else $error("page 0 write did not set gain trim");

  AST_BOOST_PAGE_B: assert property (
    s_cfg_write_b |=> boost == $past(req_wdata[13]))
    else $error("page 1 write did not set range boost");

  AST_OFFSET_PAGE_B: assert property (
    s_cfg_write_b |=> offset == $past(req_wdata[12:8]))
    else $error("page 1 write did not set offset trim");

  AST_SHARED_TRIM: assert property (
    s_cfg_write_b |=> $stable(trim) && $stable(ceiling_a))
    else $error("page 1 write disturbed page 0 fields");

  AST_CEILING_PAGED: assert property (
    s_cfg_write_b ##1 s_cfg_read_a |=> rsp_valid && !rsp_nak
      && rsp_data[7:0] == ceiling_a && ceiling_b == $past(req_wdata[7:0], 2))
    else $error("ceiling not kept per page");

  AST_READ_CFG_A: assert property (
    s_cfg_read_a |=> rsp_valid && rsp_data == {$past(trim), $past(ceiling_a)})
    else $error("page 0 read returned wrong fields");

  AST_RGAIN_WRITE: assert property (
    (req_valid && req_write && !nvm_load && req_cmd == CMD_INPUT_GAIN_SELECT
      && req_page == PAGE_CHAN_A) |=> rgain == $past(req_wdata[15:14]))
    else $error("resistance code not written");

  AST_NVM_LOAD: assert property (
    nvm_load |=> trim == $past(nvm_config_a[15:8])
      && offset == $past(nvm_config_b[12:8]) && rgain == $past(nvm_gain_select[15:14]))
    else $error("nonvolatile image not loaded");
endmodule // input_cal_regs

// ==== verilog/cal_pkg.sv ====
// constants for the input current sense calibration block
package cal_pkg;
  localparam logic [7:0]  CMD_INPUT_SENSE_CONFIG = 8'hda;
  localparam logic [7:0]  CMD_INPUT_GAIN_SELECT  = 8'hdc;
  localparam logic [7:0]  PAGE_CHAN_A            = 8'h00;
  localparam logic [7:0]  PAGE_CHAN_B            = 8'h01;
  // input_sense_config field positions
  localparam int          TRIM_MSB               = 15;
  localparam int          TRIM_LSB               = 8;
  localparam int          BOOST_BIT              = 13;
  localparam int          OFFSET_MSB             = 12;
  localparam int          OFFSET_LSB             = 8;
  localparam int          CEILING_MSB            = 7;
  localparam int          CEILING_LSB            = 0;
  // input_gain_select field positions
  localparam int          RGAIN_MSB              = 15;
  localparam int          RGAIN_LSB              = 14;
  localparam int          FACTORY_MSB            = 12;
  localparam int          FACTORY_LSB            = 0;
  // values held before the nonvolatile image is loaded
  localparam logic [7:0]  TRIM_RESET             = 8'h00;
  localparam logic [4:0]  OFFSET_RESET           = 5'h00;
  localparam logic [7:0]  CEILING_RESET          = 8'h00;
  localparam logic [1:0]  RGAIN_RESET            = 2'h0;
  localparam logic [12:0] FACTORY_RESET          = 13'h0000;
  // nominal gain trim; trim/nominal scales the reported current
  localparam logic [7:0]  TRIM_NOMINAL           = 8'h32;
  // analog gain in units of 0.05 milliohm, index {boost, rgain}
  localparam logic [6:0]  SENSE_GAIN_TBL [8]     = '{7'h03, 7'h05, 7'h06, 7'h0a,
                                                     7'h18, 7'h28, 7'h30, 7'h50};
  // uV / (0.05 mohm * code) -> 0.1 A needs a factor of 5
  localparam logic [14:0] GAIN_DEN_SCALE         = 15'(5 * int'(TRIM_NOMINAL));
  // ceiling in 1 A steps against current in 0.1 A steps
  localparam logic [11:0] CEILING_SCALE          = 12'h00a;
endpackage

// ==== verilog/iin_calc.sv ====
// telemetry arithmetic that applies the calibration settings
`timescale 1ns/100ps
module iin_calc
  import cal_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [15:0]        sense_uv,
  input  wire logic [11:0]        iout_a_raw,
  input  wire logic [11:0]        iout_b_raw,
  input  wire logic [7:0]         trim,
  input  wire logic               boost,
  input  wire logic [1:0]         rgain,
  input  wire logic [4:0]         offset,
  input  wire logic [7:0]         ceiling_a,
  input  wire logic [7:0]         ceiling_b,
  output logic signed [25:0]      iin_report,
  output logic [11:0]             iout_a_report,
  output logic [11:0]             iout_b_report,
  output logic                    iout_a_over,
  output logic                    iout_b_over
);
  logic [6:0]         gain_code;
  logic [23:0]        num;
  logic [14:0]        den;
  logic [23:0]        quot;
  logic [11:0]        limit_a;
  logic [11:0]        limit_b;
  logic signed [25:0] next_iin_report;
  logic [11:0]        next_iout_a_report;
  logic [11:0]        next_iout_b_report;
  logic               next_iout_a_over;
  logic               next_iout_b_over;

  always_comb begin
    gain_code          = SENSE_GAIN_TBL[{boost, rgain}];
    num                = 24'(sense_uv) * 24'(trim);
    den                = GAIN_DEN_SCALE * 15'(gain_code);
    quot               = num / 24'(den);
    next_iin_report    = $signed({2'b00, quot})
                         + $signed({{21{offset[4]}}, offset});
    limit_a            = 12'(ceiling_a) * CEILING_SCALE;
    limit_b            = 12'(ceiling_b) * CEILING_SCALE;
    next_iout_a_over   = iout_a_raw > limit_a;
    next_iout_b_over   = iout_b_raw > limit_b;
    next_iout_a_report = next_iout_a_over ? limit_a : iout_a_raw;
    next_iout_b_report = next_iout_b_over ? limit_b : iout_b_raw;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      iin_report    <= '0;
      iout_a_report <= '0;
      iout_b_report <= '0;
      iout_a_over   <= 1'b0;
      iout_b_over   <= 1'b0;
    end else begin
      iin_report    <= next_iin_report;
      iout_a_report <= next_iout_a_report;
      iout_b_report <= next_iout_b_report;
      iout_a_over   <= next_iout_a_over;
      iout_b_over   <= next_iout_b_over;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_NOMINAL_GAIN: assert property (
    (trim == TRIM_NOMINAL && !boost && rgain == 2'h3 && offset == 5'h00)
      |=> iin_report == $signed({10'h000, 16'($past(sense_uv) / 16'd50)}))
    else $error("nominal trim at 0.5 mohm gives wrong current");

  AST_HALF_TRIM: assert property (
    (trim == 8'd25 && !boost && rgain == 2'h3 && offset == 5'h00)
      |=> iin_report == $signed({10'h000, 16'($past(sense_uv) / 16'd100)}))
    else $error("half trim does not halve the gain");

  AST_OFFSET_ONLY: assert property (
    (sense_uv == 16'h0000)
      |=> iin_report == $signed({{21{$past(offset[4])}}, $past(offset)}))
    else $error("offset code not added as signed tenths");

  AST_CEILING_A: assert property (
    (iout_a_raw > 12'(ceiling_a) * CEILING_SCALE)
      |=> iout_a_over && iout_a_report == 12'($past(ceiling_a)) * CEILING_SCALE)
    else $error("channel a current not held at ceiling");
endmodule // iin_calc

// ==== bench/cal_host.sv ====
// host model issuing word reads and writes to the calibration registers
`timescale 1ns/100ps
module cal_host (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_nak,
  input  wire logic [15:0] rsp_data,
  output logic             req_valid,
  output logic             req_write,
  output logic [7:0]       req_cmd,
  output logic [7:0]       req_page,
  output logic [15:0]      req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cmd   = 8'h00;
    req_page  = 8'h00;
    req_wdata = 16'h0000;
  end
  // one word transfer; answer taken in the cycle after the request
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] page,
                      input logic [15:0] wd, output logic nak, output logic [15:0] rd);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_cmd   = cmd;
    req_page  = page;
    req_wdata = wd;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // released data does not keep its last value
    req_wdata = ~wd;
    nak       = (rsp_valid === 1'b1) ? rsp_nak : 1'bx;
    rd        = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask
  // write on one edge, read on the very next; each answer taken a cycle after its request
  task automatic wr_rd(input logic [7:0] cmd, input logic [7:0] wpage, input logic [15:0] wd,
                       input logic [7:0] rpage, output logic nak, output logic [15:0] rd);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_cmd   = cmd;
    req_page  = wpage;
    req_wdata = wd;
    @(posedge clk);
    #1;
    nak       = (rsp_valid === 1'b1) ? rsp_nak : 1'bx;
    req_write = 1'b0;
    req_page  = rpage;
    req_wdata = ~wd;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    rd        = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask
  // full calibration pass over both pages
  task automatic calibrate(input logic [7:0] trim, input logic boost, input logic [1:0] rg,
                           input logic [4:0] ofs, input logic [7:0] ca, input logic [7:0] cb);
    logic        nak;
    logic [15:0] rd;
    xfer(1'b1, 8'hdc, 8'h00, {rg, 1'b0, 13'h1fff}, nak, rd);
    xfer(1'b1, 8'hda, 8'h00, {trim, ca}, nak, rd);
    xfer(1'b1, 8'hda, 8'h01, {2'b00, boost, ofs, cb}, nak, rd);
  endtask
endmodule // cal_host

// ==== bench/tb_top.sv ====
// self-checking bench for the calibration register block
`timescale 1ns/100ps
module tb_top;
  import cal_pkg::*;
  logic               clk = 1'b0;
  logic               rst_b, req_valid, req_write, rsp_valid, rsp_nak, nvm_load;
  logic [7:0]         req_cmd, req_page;
  logic [15:0]        req_wdata, rsp_data, nvm_config_a, nvm_config_b, nvm_gain_select;
  logic [15:0]        sense_uv;
  logic [11:0]        iout_a_raw, iout_b_raw, iout_a_report, iout_b_report;
  logic signed [25:0] iin_report;
  logic               iout_a_over, iout_b_over, nak;
  logic [15:0]        rd;
  int                 fail_count = 0;
  int                 n_checks = 0;
  int                 gtab [8] = '{3, 5, 6, 10, 24, 40, 48, 80};
  always #2 clk = ~clk;
  cal_host host (.clk(clk), .rsp_valid(rsp_valid), .rsp_nak(rsp_nak), .rsp_data(rsp_data),
    .req_valid(req_valid), .req_write(req_write), .req_cmd(req_cmd), .req_page(req_page),
    .req_wdata(req_wdata));
  input_cal_regs DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
    .req_cmd(req_cmd), .req_page(req_page), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_nak(rsp_nak), .rsp_data(rsp_data), .nvm_load(nvm_load), .nvm_config_a(nvm_config_a),
    .nvm_config_b(nvm_config_b), .nvm_gain_select(nvm_gain_select), .sense_uv(sense_uv),
    .iout_a_raw(iout_a_raw), .iout_b_raw(iout_b_raw), .iin_report(iin_report),
    .iout_a_report(iout_a_report), .iout_b_report(iout_b_report),
    .iout_a_over(iout_a_over), .iout_b_over(iout_b_over));
  task automatic chk(input string what, input logic [25:0] exp, input logic [25:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [7:0] page,
                        input logic [15:0] exp);
    host.xfer(1'b0, cmd, page, 16'h0000, nak, rd);
    chk(what, 26'(exp), 26'(rd));
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_nvm();
    rd_chk("cfg p0 before load", 8'hda, 8'h00, 16'h0000);
    @(posedge clk);
    #1;
    nvm_load = 1'b1;
    @(posedge clk);
    #1;
    nvm_load = 1'b0;
    rd_chk("cfg p0 image", 8'hda, 8'h00, 16'h40c8);
    rd_chk("cfg p1 image", 8'hda, 8'h01, 16'h3f07);
    rd_chk("gain image", 8'hdc, 8'h00, 16'hdfff);
    $display("test nvm done");
  endtask
  task automatic t_paging();
    host.xfer(1'b1, 8'hda, 8'h00, 16'h3214, nak, rd);
    host.xfer(1'b1, 8'hda, 8'h01, 16'h2d05, nak, rd);
    rd_chk("cfg p0", 8'hda, 8'h00, 16'h3214);
    rd_chk("cfg p1", 8'hda, 8'h01, 16'h2d05);
    host.xfer(1'b1, 8'hdc, 8'h01, 16'h1234, nak, rd);
    chk("gain p1 write nak", 26'(nak), 26'h0);
    rd_chk("gain p1", 8'hdc, 8'h01, 16'h0000);
    host.xfer(1'b0, 8'h99, 8'h00, 16'h0000, nak, rd);
    chk("bad cmd nak", 26'(nak), 26'h1);
    host.xfer(1'b1, 8'hda, 8'hff, 16'hffff, nak, rd);
    chk("bad page nak", 26'(nak), 26'h1);
    rd_chk("cfg p0 kept", 8'hda, 8'h00, 16'h3214);
    host.wr_rd(8'hda, 8'h01, 16'h0e21, 8'h00, nak, rd);
    chk("b2b write nak", 26'(nak), 26'h0);
    chk("b2b read p0", 26'(rd), 26'h3214);
    rd_chk("cfg p1 after b2b", 8'hda, 8'h01, 16'h0e21);
    $display("test paging done");
  endtask
  task automatic t_gain();
    sense_uv = 16'd10000;
    for (int i = 0; i < 8; i++) begin
      host.calibrate(8'd50, i[2], i[1:0], 5'h00, 8'h14, 8'h0f);
      settle();
      chk("iin gain", 26'(2000 / gtab[i]), iin_report);
    end
    host.calibrate(8'd25, 1'b0, 2'b11, 5'h00, 8'h14, 8'h0f);
    settle();
    chk("iin half trim", 26'd100, iin_report);
    $display("test gain done");
  endtask
  task automatic t_offset();
    sense_uv = 16'd0;
    for (int c = 0; c < 32; c++) begin
      host.xfer(1'b1, 8'hda, 8'h01, {3'b000, c[4:0], 8'h0f}, nak, rd);
      settle();
      chk("iin offset", 26'(c < 16 ? c : c - 32), iin_report);
    end
    $display("test offset done");
  endtask
  task automatic t_ceiling();
    iout_a_raw = 12'd201;
    iout_b_raw = 12'd150;
    settle();
    chk("a over", 26'(iout_a_over), 26'h1);
    chk("a clamp", 26'(iout_a_report), 26'd200);
    chk("b over", 26'(iout_b_over), 26'h0);
    chk("b pass", 26'(iout_b_report), 26'd150);
    $display("test ceiling done");
  endtask
  initial begin
    rst_b = 1'b0;
    nvm_load = 1'b0;
    nvm_config_a = 16'h40c8;
    nvm_config_b = 16'hff07;
    nvm_gain_select = 16'hffff;
    sense_uv = 16'h0000;
    iout_a_raw = 12'h000;
    iout_b_raw = 12'h000;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_nvm();
    t_paging();
    t_gain();
    t_offset();
    t_ceiling();
    close_out();
  end
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule // tb_top
